// [logic/gov_cmd_logic.sv]
// Governor command logic: contacts, speed pickup, reference and fuel limit.
// Assumes setpoints arrive on clk_in from configuration logic; contacts and
// the pickup are asynchronous pins.
`timescale 1ns/1ps
module gov_cmd_logic #(
   parameter int unsigned DEBOUNCE_CYCLES = gov_cmd_pkg::DEBOUNCE_CYC,
   parameter int unsigned GATE_CYCLES = gov_cmd_pkg::GATE_CYC,
   parameter int unsigned LOSS_CYCLES = gov_cmd_pkg::LOSS_CYC,
   parameter int unsigned TICK_CYCLES = gov_cmd_pkg::TICK_CYC,
   parameter int unsigned DIAG_CYCLES = gov_cmd_pkg::DIAG_CYC
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_b_in,
   // Contact pins
   input wire logic run_permit_in,
   input wire logic idle_rated_in,
   input wire logic lower_in,
   input wire logic raise_in,
   input wire logic dyn_select_in,
   input wire logic speed_ovr_in,
   // Speed pickup pin
   input wire logic pickup_in,
   // Setpoints
   input wire logic [gov_cmd_pkg::SPD_W-1:0] rated_sp_in,
   input wire logic [gov_cmd_pkg::SPD_W-1:0] idle_sp_in,
   input wire logic [gov_cmd_pkg::SPD_W-1:0] remote_ref_in,
   input wire logic [gov_cmd_pkg::SPD_W-1:0] raise_rate_in,
   input wire logic [gov_cmd_pkg::SPD_W-1:0] lower_rate_in,
   input wire logic [gov_cmd_pkg::SPD_W-1:0] ramp_rate_in,
   input wire logic [gov_cmd_pkg::SPD_W-1:0] teeth_in,
   input wire logic [gov_cmd_pkg::SPD_W-1:0] start_fuel_lim_in,
   input wire logic [gov_cmd_pkg::SPD_W-1:0] max_fuel_lim_in,
   input wire logic [gov_cmd_pkg::SPD_W-1:0] torque_lim_in,
   input wire logic torque_sel_in,
   // Actuator side
   output logic act_enable_out,
   output logic min_fuel_out,
   output logic [gov_cmd_pkg::SPD_W-1:0] fuel_limit_out,
   output logic [gov_cmd_pkg::SPD_W-1:0] speed_ref_out,
   // Status
   output logic dyn_set_out,
   output logic remote_mode_out,
   output logic ramp_active_out,
   output logic idle_clamped_out,
   output logic [gov_cmd_pkg::SPD_W-1:0] rpm_out,
   output logic speed_lost_out,
   output logic diag_done_out,
   output logic diag_fail_out
);
   import gov_cmd_pkg::*;

   // ----------------------------------------------------------------
   // Arithmetic helpers
   // ----------------------------------------------------------------
   function automatic logic [SPD_W-1:0] sat_add(input logic [SPD_W-1:0] a,
                                                input logic [SPD_W-1:0] b);
      logic [SPD_W:0] sum;
      sum = {1'b0, a} + {1'b0, b};
      return sum[SPD_W] ? SPD_MAX : sum[SPD_W-1:0];
   endfunction : sat_add

   function automatic logic [SPD_W-1:0] sat_sub(input logic [SPD_W-1:0] a,
                                                input logic [SPD_W-1:0] b);
      return (a > b) ? SPD_W'(a - b) : '0;
   endfunction : sat_sub

   // One ramp step from cur toward tgt, never overshooting
   function automatic logic [SPD_W-1:0] step_toward(input logic [SPD_W-1:0] cur,
                                                    input logic [SPD_W-1:0] tgt,
                                                    input logic [SPD_W-1:0] rate);
      if (cur < tgt) begin
         return (SPD_W'(tgt - cur) <= rate) ? tgt : SPD_W'(cur + rate);
      end
      return (SPD_W'(cur - tgt) <= rate) ? tgt : SPD_W'(cur - rate);
   endfunction : step_toward

   function automatic logic [SPD_W-1:0] rpm_calc(input logic [SPD_W-1:0] pulses,
                                                 input logic [SPD_W-1:0] teeth);
      logic [CNT_W-1:0] prod;
      logic [CNT_W-1:0] quo;
      prod = CNT_W'(pulses) * CNT_W'(RPM_SCALE);
      quo = (teeth == '0) ? '0 : prod / CNT_W'(teeth);
      return (quo > CNT_W'(SPD_MAX)) ? SPD_MAX : quo[SPD_W-1:0];
   endfunction : rpm_calc

   // ----------------------------------------------------------------
   // Contact conditioning
   // ----------------------------------------------------------------
   logic [NUM_CONTACTS-1:0] raw_ct;
   logic [NUM_CONTACTS-1:0] db_ct;

   assign raw_ct = {speed_ovr_in, dyn_select_in, raise_in, lower_in, idle_rated_in,
                    run_permit_in};

   for (genvar i = 0; i < NUM_CONTACTS; i++) begin : g_db
      contact_debounce #(
         .STABLE_CYC(DEBOUNCE_CYCLES)
      ) u_db (
         .clk_in(clk_in),
         .rst_b_in(rst_b_in),
         .raw_in(raw_ct[i]),
         .level_out(db_ct[i])
      );
   end

   logic run_db;
   logic rated_db;
   logic lower_db;
   logic raise_db;
   logic ovr_db;
   logic remote_req;
   logic [SPD_W-1:0] idle_eff;
   logic [SPD_W-1:0] rated_lim;
   logic [SPD_W-1:0] ramp_tgt;

   assign run_db = db_ct[CT_RUN];
   assign rated_db = db_ct[CT_RATED];
   assign lower_db = db_ct[CT_LOWER];
   assign raise_db = db_ct[CT_RAISE];
   assign ovr_db = db_ct[CT_OVR];
   assign remote_req = raise_db && lower_db;
   // Idle can never sit above rated
   assign idle_eff = (idle_sp_in > rated_sp_in) ? rated_sp_in : idle_sp_in;
   assign rated_lim = torque_sel_in ? torque_lim_in : max_fuel_lim_in;
   // Remote value replaces rated only while remote mode is held
   assign ramp_tgt = !rated_db ? idle_eff : (remote_req ? remote_ref_in : rated_sp_in);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic sp1;
      logic sp2;
      logic sp3;
      logic [CNT_W-1:0] gate_cnt;
      logic [SPD_W-1:0] pulse_cnt;
      logic [CNT_W-1:0] loss_cnt;
      logic lost;
      logic [SPD_W-1:0] rpm;
      logic [CNT_W-1:0] tick_cnt;
      logic [CNT_W-1:0] diag_cnt;
      logic diag_done;
      logic diag_fail;
      logic rated_prev;
      ref_mode_t mode;
      logic ramp;
      logic [SPD_W-1:0] spd_ref;
      logic [SPD_W-1:0] fuel;
      logic act_en;
      logic min_fuel;
      logic dyn;
      logic remote;
      logic clamped;
   } gov_state_t;

   gov_state_t s_q;
   gov_state_t s_d;
   logic pulse_edge;
   logic tick;

   assign pulse_edge = s_q.sp2 && !s_q.sp3;
   assign tick = (s_q.tick_cnt >= CNT_W'(TICK_CYCLES - 1));

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      // Pickup: the first flop feeds only the second
      s_d.sp1 = pickup_in;
      s_d.sp2 = s_q.sp1;
      s_d.sp3 = s_q.sp2;

      // Frequency gate; the rpm figure updates once per gate
      if (s_q.gate_cnt >= CNT_W'(GATE_CYCLES - 1)) begin
         s_d.gate_cnt = '0;
         s_d.rpm = rpm_calc(s_q.pulse_cnt, teeth_in);
         s_d.pulse_cnt = pulse_edge ? SPD_W'(1) : '0;
      end else begin
         s_d.gate_cnt = s_q.gate_cnt + 1'b1;
         if (pulse_edge && s_q.pulse_cnt != SPD_MAX) begin
            s_d.pulse_cnt = s_q.pulse_cnt + 1'b1;
         end
      end

      // Loss detector: no pulse for a whole loss interval
      if (pulse_edge) begin
         s_d.loss_cnt = '0;
         s_d.lost = 1'b0;
      end else if (s_q.loss_cnt >= CNT_W'(LOSS_CYCLES - 1)) begin
         s_d.lost = 1'b1;
      end else begin
         s_d.loss_cnt = s_q.loss_cnt + 1'b1;
      end

      // Power-up check of configuration, then latched verdict
      if (!s_q.diag_done) begin
         if (s_q.diag_cnt >= CNT_W'(DIAG_CYCLES - 1)) begin
            s_d.diag_done = 1'b1;
            s_d.diag_fail = (teeth_in == '0) || (start_fuel_lim_in > max_fuel_lim_in);
         end else begin
            s_d.diag_cnt = s_q.diag_cnt + 1'b1;
         end
      end

      // Reference stepping clock
      s_d.tick_cnt = tick ? '0 : s_q.tick_cnt + 1'b1;

      // Speed reference; contact edge restarts a ramp, manual contacts win
      s_d.rated_prev = rated_db;
      if (rated_db != s_q.rated_prev) begin
         s_d.mode = REF_RAMP;
      end
      if (remote_req) begin
         s_d.mode = REF_HOLD;
         if (tick) begin
            s_d.spd_ref = step_toward(s_q.spd_ref, ramp_tgt, ramp_rate_in);
         end
      end else if (raise_db || lower_db) begin
         s_d.mode = REF_HOLD;
         if (tick && raise_db) begin
            s_d.spd_ref = sat_add(s_q.spd_ref, raise_rate_in);
         end else if (tick) begin
            s_d.spd_ref = sat_sub(s_q.spd_ref, lower_rate_in);
         end
      end else if (s_q.mode == REF_RAMP && tick) begin
         s_d.spd_ref = step_toward(s_q.spd_ref, ramp_tgt, ramp_rate_in);
         if (s_d.spd_ref == ramp_tgt) begin
            s_d.mode = REF_HOLD;
         end
      end
      s_d.ramp = (s_d.mode == REF_RAMP);

      // Limiter follows the rated contact and torque_sel_in, never the remote selection
      s_d.fuel = rated_db ? rated_lim : start_fuel_lim_in;

      // Actuator permission
      s_d.act_en = run_db && s_q.diag_done && !s_q.diag_fail
                   && !(s_q.lost && !ovr_db);
      s_d.min_fuel = !s_d.act_en;
      s_d.dyn = db_ct[CT_DYN];
      s_d.remote = remote_req;
      s_d.clamped = (idle_sp_in > rated_sp_in);
   end

   // State register; pickup counts as lost until the first pulses arrive
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         s_q <= '0;
         s_q.lost <= 1'b1;
         s_q.mode <= REF_RAMP;
         s_q.ramp <= 1'b1;
         s_q.spd_ref <= REF_RST;
         s_q.min_fuel <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign act_enable_out = s_q.act_en;
   assign min_fuel_out = s_q.min_fuel;
   assign fuel_limit_out = s_q.fuel;
   assign speed_ref_out = s_q.spd_ref;
   assign dyn_set_out = s_q.dyn;
   assign remote_mode_out = s_q.remote;
   assign ramp_active_out = s_q.ramp;
   assign idle_clamped_out = s_q.clamped;
   assign rpm_out = s_q.rpm;
   assign speed_lost_out = s_q.lost;
   assign diag_done_out = s_q.diag_done;
   assign diag_fail_out = s_q.diag_fail;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);

   a_run_gate: assert property (!run_db |=> !act_enable_out && min_fuel_out)
      else $error("actuator enabled without run permit");
   a_fuel_rated: assert property ($rose(rated_db) |=> fuel_limit_out == $past(rated_lim))
      else $error("rated limit not applied at once");
   a_fuel_idle: assert property (!rated_db |=> fuel_limit_out == $past(start_fuel_lim_in))
      else $error("start limit not applied in idle");
   a_idle_clamp: assert property (idle_clamped_out |-> $past(idle_eff == rated_sp_in))
      else $error("idle target above rated");
   a_hold_ref: assert property (!remote_req && !raise_db && !lower_db && !s_q.ramp
                                |=> $stable(speed_ref_out))
      else $error("reference moved while held");
   a_lower_step: assert property (tick && lower_db && !raise_db
                                  && speed_ref_out > lower_rate_in
                                  |=> speed_ref_out == $past(speed_ref_out - lower_rate_in))
      else $error("lower step wrong");
   a_raise_step: assert property (tick && raise_db && !lower_db
                                  && speed_ref_out < 16'h8000 && raise_rate_in < 16'h8000
                                  |=> speed_ref_out == $past(speed_ref_out + raise_rate_in))
      else $error("raise step wrong");
   a_abort_ramp: assert property ((raise_db || lower_db) |=> !ramp_active_out)
      else $error("ramp not aborted");
   a_remote_mode: assert property (remote_req |=> remote_mode_out && !ramp_active_out)
      else $error("remote mode not entered");
   a_dyn_select: assert property (dyn_set_out == $past(db_ct[CT_DYN]))
      else $error("dynamics set mismatch");
   a_lost_minfuel: assert property (speed_lost_out && !ovr_db |=> min_fuel_out)
      else $error("lost speed did not force minimum fuel");
   a_ovr_crank: assert property (ovr_db && run_db && diag_done_out && !diag_fail_out
                                 |=> act_enable_out)
      else $error("override did not allow actuator");
   a_diag_fail: assert property (diag_fail_out || !diag_done_out |=> min_fuel_out)
      else $error("actuator enabled without passing diagnostics");

   c_ramp_done: cover property (ramp_active_out ##1 !ramp_active_out);
   c_remote: cover property ($rose(remote_mode_out));
   c_crank: cover property (speed_lost_out && act_enable_out);

endmodule : gov_cmd_logic

// [pkg/gov_cmd_pkg.sv]
// Constants, timing and types for the governor discrete command logic.
// Assumes a single 125 MHz clock; all times are converted to cycles here.
package gov_cmd_pkg;

   // ----------------------------------------------------------------
   // Clock and times
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 125;
   localparam int DEBOUNCE_US = 5000;
   localparam int GATE_US = 100000;
   localparam int LOSS_US = 500000;
   localparam int TICK_US = 10000;
   localparam int DIAG_US = 1000;
   localparam int DEBOUNCE_CYC = DEBOUNCE_US * CLK_MHZ;
   localparam int GATE_CYC = GATE_US * CLK_MHZ;
   localparam int LOSS_CYC = LOSS_US * CLK_MHZ;
   localparam int TICK_CYC = TICK_US * CLK_MHZ;
   localparam int DIAG_CYC = DIAG_US * CLK_MHZ;

   // ----------------------------------------------------------------
   // Widths, scaling and reset values
   // ----------------------------------------------------------------
   localparam int SPD_W = 16;
   localparam int CNT_W = 32;
   localparam int NUM_CONTACTS = 6;
   // Pulses per gate times this, over the tooth count, gives rpm
   localparam int RPM_SCALE = 60000000 / GATE_US;
   localparam logic [SPD_W-1:0] SPD_MAX = 16'hffff;
   localparam logic [SPD_W-1:0] REF_RST = 16'h0000;

   // Contact positions in the debounced vector
   localparam int CT_RUN = 0;
   localparam int CT_RATED = 1;
   localparam int CT_LOWER = 2;
   localparam int CT_RAISE = 3;
   localparam int CT_DYN = 4;
   localparam int CT_OVR = 5;

   typedef enum logic {REF_HOLD, REF_RAMP} ref_mode_t;

endpackage : gov_cmd_pkg

// [logic/contact_debounce.sv]
// Two-flop synchroniser and stability filter for one switch contact.
// Assumes the raw contact is asynchronous to clk_in.
`timescale 1ns/1ps
module contact_debounce #(
   parameter int unsigned STABLE_CYC = gov_cmd_pkg::DEBOUNCE_CYC
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_b_in,
   // Contact
   input wire logic raw_in,
   output logic level_out
);
   import gov_cmd_pkg::*;

   typedef struct packed {
      logic s1;
      logic s2;
      logic level;
      logic [CNT_W-1:0] cnt;
   } db_state_t;

   db_state_t s_q;
   db_state_t s_d;

   // ----------------------------------------------------------------
   // Filter: level follows only after a full stable interval
   // ----------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.s1 = raw_in;
      s_d.s2 = s_q.s1;
      if (s_q.s2 == s_q.level) begin
         s_d.cnt = '0;
      end else if (s_q.cnt >= CNT_W'(STABLE_CYC - 1)) begin
         s_d.level = s_q.s2;
         s_d.cnt = '0;
      end else begin
         s_d.cnt = s_q.cnt + 1'b1; // Bounce restarts the count
      end
   end

   // State register
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign level_out = s_q.level;

endmodule : contact_debounce

// [testbench/field_contact_model.sv]
// Field side model: six switch contacts and a magnetic speed pickup.
// Assumes the bench changes its commands at falling edges of clk_in.
`timescale 1ns/1ps
module field_contact_model (
   // Clock
   input wire logic clk_in,
   // Commands from the bench
   input wire logic [5:0] cmd_in,
   input wire logic bounce_in,
   input wire logic [15:0] period_in,
   // Pins towards the governor
   output logic [5:0] contacts_out,
   output logic pickup_out
);
   // ---------------------------------------------------------------
   // Chatter and pulse timing
   // ---------------------------------------------------------------
   logic tgl_q = 1'b0;
   logic [15:0] cnt_q = 16'h0000;

   // Pulse counter wraps at the commanded period; zero means engine at rest
   always_ff @(posedge clk_in) begin
      tgl_q <= ~tgl_q;
      cnt_q <= (cnt_q + 16'h0001 >= period_in) ? 16'h0000 : cnt_q + 16'h0001;
   end

   // Bounce flips every contact each cycle, so no level ever looks stable
   assign contacts_out = cmd_in ^ {6{bounce_in & tgl_q}};
   // A stopped pickup gives a flat low line, never a stale pulse
   assign pickup_out = (period_in != 16'h0000) && (cnt_q < (period_in >> 1));
endmodule : field_contact_model

// [testbench/tb_governor_discrete_command_logic.sv]
// Self-checking bench for the governor command logic.
// Assumes shortened counts: debounce 4, gate 200, loss 50, tick 10, diag 8.
`timescale 1ns/1ps
module tb_governor_discrete_command_logic;
   import gov_cmd_pkg::*;
   // ---------------------------------------------------------------
   // Stimulus and observation signals
   // ---------------------------------------------------------------
   logic clk_in = 1'b0;
   logic rst_b_in = 1'b0;
   logic [5:0] cmd = 6'h00;
   logic bounce = 1'b0;
   logic [15:0] period = 16'h0000;
   logic [5:0] pins;
   logic pickup;
   logic [SPD_W-1:0] rated_sp = 16'h03e8, idle_sp = 16'h0190, remote_ref = 16'h02bc;
   logic [SPD_W-1:0] teeth = 16'h0004;
   logic [SPD_W-1:0] raise_rate = 16'h0007, lower_rate = 16'h0005, ramp_rate = 16'h0064;
   logic [SPD_W-1:0] start_lim = 16'h0100, max_lim = 16'h0800, torque_lim = 16'h0600;
   logic torque_sel = 1'b0;
   logic act_en, min_fuel, dyn_set, remote, ramp_act, clamped, lost, dg_done, dg_fail;
   logic [SPD_W-1:0] fuel, sref, rpm, r0;
   int error_cnt = 0;
   int compares = 0;

   // 125 MHz clock
   always #4 clk_in = ~clk_in;

   field_contact_model model_u (.clk_in(clk_in), .cmd_in(cmd), .bounce_in(bounce),
      .period_in(period), .contacts_out(pins), .pickup_out(pickup));

   gov_cmd_logic #(.DEBOUNCE_CYCLES(4), .GATE_CYCLES(200), .LOSS_CYCLES(50),
      .TICK_CYCLES(10), .DIAG_CYCLES(8)) dut_u (
      .clk_in(clk_in), .rst_b_in(rst_b_in), .run_permit_in(pins[CT_RUN]),
      .idle_rated_in(pins[CT_RATED]), .lower_in(pins[CT_LOWER]), .raise_in(pins[CT_RAISE]),
      .dyn_select_in(pins[CT_DYN]), .speed_ovr_in(pins[CT_OVR]), .pickup_in(pickup),
      .rated_sp_in(rated_sp), .idle_sp_in(idle_sp), .remote_ref_in(remote_ref),
      .raise_rate_in(raise_rate), .lower_rate_in(lower_rate), .ramp_rate_in(ramp_rate),
      .teeth_in(teeth), .start_fuel_lim_in(start_lim), .max_fuel_lim_in(max_lim),
      .torque_lim_in(torque_lim), .torque_sel_in(torque_sel), .act_enable_out(act_en),
      .min_fuel_out(min_fuel), .fuel_limit_out(fuel), .speed_ref_out(sref),
      .dyn_set_out(dyn_set), .remote_mode_out(remote), .ramp_active_out(ramp_act),
      .idle_clamped_out(clamped), .rpm_out(rpm), .speed_lost_out(lost),
      .diag_done_out(dg_done), .diag_fail_out(dg_fail));

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic settle(input int n);
      repeat (n) @(negedge clk_in);
   endtask : settle

   // Debounce plus registering needs about eight cycles; twenty leaves margin
   task automatic set(input int idx, input logic v);
      cmd[idx] = v;
      settle(20);
   endtask : set

   // Bounded wait for an idle or rated ramp to finish
   task automatic wait_ramp();
      int n;
      n = 0;
      while (ramp_act !== 1'b0 && n < 300) begin
         @(negedge clk_in);
         n++;
      end
   endtask : wait_ramp

   // Waits for the next reference step and checks its size
   task automatic step_by(input string name, input logic [15:0] delta, input bit up);
      int n;
      r0 = sref;
      n = 0;
      while (sref === r0 && n < 40) begin
         @(negedge clk_in);
         n++;
      end
      chk(name, up ? sref - r0 : r0 - sref, delta);
   endtask : step_by

   task automatic do_reset();
      rst_b_in = 1'b0;
      settle(5);
      rst_b_in = 1'b1;
   endtask : do_reset

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : conclude

   // Watchdog well beyond the roughly 1300 cycles the tests need
   initial begin
      repeat (20000) @(posedge clk_in);
      error_cnt++;
      conclude();
   end

   // ---------------------------------------------------------------
   // Test sequence
   // ---------------------------------------------------------------
   initial begin
      settle(1);
      chk("act in reset", act_en, 1'b0);
      chk("min fuel in reset", min_fuel, 1'b1);
      do_reset();
      settle(20);
      chk("diag done", dg_done, 1'b1);
      chk("diag fail", dg_fail, 1'b0);
      chk("idle fuel", fuel, 16'h0100);
      wait_ramp();
      chk("ref at idle", sref, idle_sp);
      // No speed signal and override open keeps minimum fuel
      set(CT_RUN, 1'b1);
      chk("act lost speed", act_en, 1'b0);
      chk("min fuel lost", min_fuel, 1'b1);
      set(CT_OVR, 1'b1);
      chk("act override", act_en, 1'b1);
      set(CT_RUN, 1'b0);
      chk("act no permit", act_en, 1'b0);
      set(CT_RUN, 1'b1);
      set(CT_DYN, 1'b1);
      chk("dyn two", dyn_set, 1'b1);
      set(CT_DYN, 1'b0);
      chk("dyn one", dyn_set, 1'b0);
      // Chatter and a short glitch must both be filtered out
      bounce = 1'b1;
      set(CT_DYN, 1'b1);
      chk("dyn bounce", dyn_set, 1'b0);
      bounce = 1'b0;
      settle(20);
      cmd[CT_DYN] = 1'b0;
      settle(2);
      set(CT_DYN, 1'b1);
      chk("dyn glitch", dyn_set, 1'b1);
      set(CT_DYN, 1'b0);
      // Idle to rated
      set(CT_RATED, 1'b1);
      chk("rated fuel", fuel, 16'h0800);
      chk("ramp running", ramp_act, 1'b1);
      wait_ramp();
      chk("ref at rated", sref, rated_sp);
      torque_sel = 1'b1;
      settle(3);
      chk("torque fuel", fuel, 16'h0600);
      torque_sel = 1'b0;
      // Both raise and lower closed select remote setting
      cmd[CT_RAISE] = 1'b1;
      set(CT_LOWER, 1'b1);
      chk("remote mode", remote, 1'b1);
      chk("remote fuel", fuel, 16'h0800);
      settle(60);
      chk("ref at remote", sref, remote_ref);
      cmd[CT_RAISE] = 1'b0;
      set(CT_LOWER, 1'b0);
      // Single raise and lower steps, then holding
      set(CT_RAISE, 1'b1);
      step_by("raise step", 16'h0007, 1'b1);
      raise_rate = 16'h000b;
      step_by("raise step b", 16'h000b, 1'b1);
      set(CT_RAISE, 1'b0);
      r0 = sref;
      settle(30);
      chk("ref holds", sref, r0);
      set(CT_LOWER, 1'b1);
      step_by("lower step", 16'h0005, 1'b0);
      set(CT_LOWER, 1'b0);
      r0 = sref;
      settle(30);
      chk("ref holds low", sref, r0);
      // Rated to idle, aborted by raise
      set(CT_RATED, 1'b0);
      chk("start fuel", fuel, 16'h0100);
      chk("ramp down", ramp_act, 1'b1);
      set(CT_RAISE, 1'b1);
      chk("ramp aborted", ramp_act, 1'b0);
      set(CT_RAISE, 1'b0);
      // Idle setting above rated is clamped
      idle_sp = 16'h05dc;
      settle(3);
      chk("idle clamped", clamped, 1'b1);
      set(CT_RATED, 1'b1);
      wait_ramp();
      set(CT_RATED, 1'b0);
      wait_ramp();
      chk("ref clamped", sref, rated_sp);
      idle_sp = 16'h0190;
      // Pickup at one pulse per 8 cycles: 25 pulses a gate, 3750 rpm
      set(CT_OVR, 1'b0);
      period = 16'h0008;
      settle(450);
      chk("speed seen", lost, 1'b0);
      chk("rpm range", 16'((rpm >= 16'h0e10) && (rpm <= 16'h0f3c)), 16'h0001);
      chk("act running", act_en, 1'b1);
      period = 16'h0000;
      settle(80);
      chk("speed lost", lost, 1'b1);
      chk("act cut", act_en, 1'b0);
      chk("min fuel cut", min_fuel, 1'b1);
      // Bad configuration fails the power-up check
      set(CT_OVR, 1'b1);
      teeth = 16'h0000;
      do_reset();
      settle(25);
      chk("diag fails", dg_fail, 1'b1);
      chk("act after fail", act_en, 1'b0);
      conclude();
   end
endmodule : tb_governor_discrete_command_logic
